// File: common/tsw_pkg.sv
// Shared constants and types of the time slot switch.
package tsw_pkg;

    // ==========================================================
    // Sizes
    localparam int NSTR = 32;
    localparam int NCH  = 32;
    localparam int HC_W = 10;
    localparam int NLOC = NSTR * NCH;

    // ==========================================================
    // Channel map word control field
    localparam int CM_HOST_BIT  = 15;
    localparam int CM_CONST_BIT = 14;
    localparam int CM_OE_BIT    = 13;
    localparam int CM_LPBK_BIT  = 12;

    // ==========================================================
    // Host address map
    localparam logic [1:0]  SEL_CTRL  = 2'h0;
    localparam logic [1:0]  SEL_DM    = 2'h1;
    localparam logic [1:0]  SEL_CM    = 2'h2;
    localparam logic [9:0]  CR_ADDR   = 10'h000;
    localparam logic [4:0]  OFS_PAGE  = 5'h01;
    localparam int          CR_OSB_BIT = 0;
    localparam int          CR_GCI_BIT = 1;
    localparam logic [15:0] CR_RESET  = 16'h0000;
    localparam logic [3:0]  OFS_RESET = 4'h0;
    localparam logic [3:0]  OFS_MAX   = 4'h9;

    // ==========================================================
    // Frame format detection and test port
    localparam logic [4:0] FMT_IDLE_EDGES = 5'h10;
    localparam logic [3:0] TAP_IR_CAPTURE = 4'h1;
    localparam logic [3:0] TAP_IR_RESET   = 4'hf;

    typedef enum logic [3:0] {
        TAP_TLR  = 4'h0, TAP_RTI  = 4'h1, TAP_SDR  = 4'h3, TAP_CDR  = 4'h2,
        TAP_SHDR = 4'h6, TAP_E1DR = 4'h7, TAP_UDR  = 4'h5, TAP_PDR  = 4'h4,
        TAP_E2DR = 4'hc, TAP_SIR  = 4'hd, TAP_CIR  = 4'hf, TAP_SHIR = 4'he,
        TAP_E1IR = 4'ha, TAP_UIR  = 4'hb, TAP_PIR  = 4'h9, TAP_E2IR = 4'h8
    } tsw_tap_t;

endpackage : tsw_pkg

// File: common/tsw_tm_if.sv
// Frame timing carried from the frame tracker to the switch core.
`timescale 1ns/1ps
`default_nettype none
interface tsw_tm_if import tsw_pkg::*; ();
    logic            tick;
    logic [HC_W-1:0] hc;
    logic            par;
    logic            gci;
    modport frm  (output tick, hc, par, gci);
    modport core (input  tick, hc, par, gci);
endinterface : tsw_tm_if
`default_nettype wire

// File: sim/tsw_tdm_model.sv
// Far-side backplane model: master clock, frame pulse, input streams, stream 0 monitor.
`timescale 1ns/1ps
`default_nettype none
module tsw_tdm_model (
    // Serial side
    output logic        mclk_o,
    output logic        frame_pulse_o,
    output logic [31:0] serial_in_o,
    input  wire logic   out0_i,
    input  wire logic   oe0_i,
    // Capture of the last frame
    output logic [7:0]  cap_o [32],
    output logic [31:0] oe_cap_o,
    output int          frames_o
);
    logic [7:0] sh;
    int         h;
    int         seed;
    initial begin
        seed = 32'h6c91413c;
        frame_pulse_o = 1'b1;
        serial_in_o = '0;
        frames_o = 0;
        forever begin
            for (h = 0; h < 1024; h++) begin
                mclk_o = h[0];  // Falling edge on even halves at 4.096 MHz.
                if (h % 4 == 0) serial_in_o = $random(seed);  // One bit per two clocks.
                if (h % 4 == 3) begin
                    sh = {sh[6:0], out0_i};  // Sample three quarters into the cell, msb first.
                    if (h % 32 == 31) cap_o[h / 32] = sh;
                    if (h % 32 == 31) oe_cap_o[h / 32] = oe0_i;
                end
                #61;
                // The pulse moves between clock edges, so the boundary edge sees it settled.
                if (h == 1) frame_pulse_o = 1'b1;
                if (h == 1023) frame_pulse_o = 1'b0;  // Low across the frame edge.
                #61.07;
            end
            frames_o++;
        end
    end
endmodule : tsw_tdm_model
`default_nettype wire

// File: sim/tsw_top_tb.sv
// Self-checking bench of the time slot switch.
`timescale 1ns/1ps
`default_nettype none
module tsw_top_tb;
    import tsw_pkg::*;
    logic        clk_i, resetn_i, out_en, cs_n, strb_n, rw, tck, tms, tdi, trst_n, any;
    logic [11:0] addr;
    logic [15:0] wdat, rdat, dbus;
    logic [31:0] sin, soe, sout, oe_cap;
    logic        data_oe, ack_n, ack_oe, tdo, tdo_oe, mclk, fp;
    logic [7:0]  cap [32];
    logic [7:0]  hbyte [32];
    int          frames, err_total, comparisons, seed, lat;
    tsw_top tsw_top_inst (.clk_i(clk_i), .resetn_i(resetn_i), .mclk_i(mclk), .frame_pulse_i(fp),
        .serial_in_streams_i(sin), .serial_output_master_enable_i(out_en), .serial_out_streams_o(sout),
        .serial_out_streams_oe_o(soe), .cs_n_i(cs_n), .data_strobe_n_i(strb_n), .rw_i(rw),
        .host_address_i(addr), .host_data_bus_i(wdat), .host_data_bus_o(dbus), .host_data_bus_oe_o(data_oe),
        .transfer_ack_n_o(ack_n), .transfer_ack_n_oe_o(ack_oe), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_o(tdo_oe));
    tsw_tdm_model tsw_tdm_model_inst (.mclk_o(mclk), .frame_pulse_o(fp), .serial_in_o(sin),
        .out0_i(sout[0]), .oe0_i(soe[0]), .cap_o(cap), .oe_cap_o(oe_cap), .frames_o(frames));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // ==========================================================
    // Tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic host(input logic c, input logic r, input logic [11:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge clk_i);
        cs_n = c;
        strb_n = 1'b0;
        rw = r;
        addr = a;
        wdat = d;
        do begin
            @(negedge clk_i);
            n++;
        end while (!(ack_oe === 1'b1 && ack_n === 1'b0) && n < 4);
        lat = n;
        rdat = dbus;
        if (r) chk("read drive", 16'h1, {15'h0, data_oe});
        cs_n = 1'b1;
        strb_n = 1'b1;
        n = 0;
        repeat (3) begin
            @(negedge clk_i);
            n += (ack_oe === 1'b1 && ack_n === 1'b1);
        end
        if (!c) chk("ack latency", 16'h1, lat[15:0]);
        if (!c) chk("ack high", 16'h1, n[15:0]);
        chk("bus float", 16'h0, {14'h0, ack_oe, data_oe});
    endtask : host
    task automatic rdchk(input logic [11:0] a, input logic [15:0] exp, input logic [15:0] m);
        host(1'b0, 1'b1, a, 16'h0);
        chk("read data", exp & m, rdat & m);
    endtask : rdchk
    task automatic tck_cyc(input logic m);
        tms = m;
        repeat (4) @(negedge clk_i);
        tck = 1'b1;
        repeat (4) @(negedge clk_i);
        tck = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask : tck_cyc
    task automatic end_sim;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    // ==========================================================
    // Scenarios
    initial begin
        seed = 32'h6c91413c;
        {resetn_i, out_en, rw, addr, wdat, tck, tms, tdi} = '0;
        cs_n = 1'b1;
        strb_n = 1'b1;
        trst_n = 1'b0;  // Test reset held low at power-up.
        err_total = 0;
        comparisons = 0;
        repeat (4) @(negedge clk_i);
        chk("reset float", 16'h0, {13'h0, |soe, ack_oe, data_oe});
        resetn_i = 1'b1;
        trst_n = 1'b1;
        host(1'b1, 1'b0, 12'h000, 16'h0001);
        chk("no select", 16'h4, lat[15:0]);
        rdchk(12'h000, 16'h0000, 16'hffff);
        host(1'b0, 1'b0, 12'h021, 16'h000f);
        rdchk(12'h021, 16'h0009, 16'h000f);
        rdchk(12'hc00, 16'h0000, 16'hffff);
        for (int i = 0; i < 8; i++) begin
            addr = {2'b10, 10'($random(seed)) | 10'h020};
            wdat = 16'($random(seed));
            host(1'b0, 1'b0, addr, wdat);
            rdchk(addr, wdat, 16'hf3ff);
        end
        out_en = 1'b1;
        for (int c = 0; c < 32; c++) begin
            hbyte[c] = 8'($random(seed));
            host(1'b0, 1'b0, 12'h800 + 12'(c), {2'b10, c != 5, 5'h10, hbyte[c]});
        end
        wait (frames == 2);
        for (int c = 0; c < 32; c++) begin
            if (c != 5) chk("host byte", {8'h0, hbyte[c]}, {8'h0, cap[c]});
        end
        chk("channel enable", 16'hffdf, oe_cap[15:0]);
        rdchk(12'h000, 16'h0000, 16'h0002);
        for (int c = 0; c < 32; c++) begin
            rdchk(12'h400 + 12'(c), {8'h0, hbyte[c]}, 16'hffff);
        end
        out_en = 1'b0;
        any = 1'b0;
        repeat (2) @(negedge clk_i);
        repeat (2000) @(negedge clk_i) any |= |soe;
        chk("standby float", 16'h0, {15'h0, any});
        host(1'b0, 1'b0, 12'h000, 16'h0001);
        any = 1'b0;
        repeat (2000) @(negedge clk_i) any |= |soe;
        chk("standby drive", 16'h1, {15'h0, any});
        resetn_i = 1'b0;
        repeat (20) @(negedge clk_i);  // Held for 100 ns.
        chk("reset float", 16'h0, {13'h0, |soe, ack_oe, data_oe});
        resetn_i = 1'b1;
        rdchk(12'h000, 16'h0000, 16'h0001);
        rdchk(12'h800, 16'h0000, 16'hffff);
        tck_cyc(1'b0);
        tck_cyc(1'b1);
        tck_cyc(1'b0);
        tck_cyc(1'b0);
        chk("scan drive", 16'h1, {15'h0, tdo_oe});
        trst_n = 1'b0;
        @(negedge clk_i);
        chk("test reset", 16'h0, {15'h0, tdo_oe});
        end_sim();
    end
    initial begin
        #400000;
        err_total++;
        end_sim();
    end
endmodule : tsw_top_tb
`default_nettype wire

// File: src/tsw_frame.sv
// Master clock edge tracking, frame format detection and half-cycle counter.
`timescale 1ns/1ps
`default_nettype none
module tsw_frame import tsw_pkg::*; (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // Serial timing pins
    input  wire logic mclk_i,
    input  wire logic frame_pulse_i,
    // Timing to the core
    tsw_tm_if.frm     tm
);
    logic            mclk_q;
    logic            fp_e;
    logic            gci;
    logic            par;
    logic            tick;
    logic [HC_W-1:0] hc;
    logic [4:0]      stab;

    wire logic rise      = mclk_i & ~mclk_q;
    wire logic fall      = ~mclk_i & mclk_q;
    wire logic mclk_edge = rise | fall;
    // A frame starts on an edge of the right kind that sees the pulse active when the edge before it saw the pulse idle.
    wire logic start     = gci ? (rise & frame_pulse_i & ~fp_e)
                               : (fall & ~frame_pulse_i & fp_e);

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            mclk_q <= 1'b0;
            fp_e   <= 1'b0;
            gci    <= 1'b0;
            par    <= 1'b0;
            tick   <= 1'b0;
            hc     <= {HC_W{1'b0}};
            stab   <= 5'h00;
        end else begin
            mclk_q <= mclk_i;
            tick   <= mclk_edge;
            if (mclk_edge) begin
                fp_e <= frame_pulse_i;
                stab <= (frame_pulse_i != fp_e) ? 5'h00
                      : (stab == FMT_IDLE_EDGES) ? stab : stab + 5'h01;
            end
            // The long-held level is the idle level; a low idle means the other format.
            if (stab == FMT_IDLE_EDGES) begin
                gci <= ~fp_e;
            end
            if (start) begin
                hc  <= {HC_W{1'b0}};
                par <= ~par;
            end else if (mclk_edge) begin
                hc <= hc + HC_W'(1);
            end
        end
    end

    assign tm.tick = tick;
    assign tm.hc   = hc;
    assign tm.par  = par;
    assign tm.gci  = gci;

    a_frame_restart: assert property (@(posedge clk_i) disable iff (!resetn_i)
        start |=> hc == {HC_W{1'b0}} && par != $past(par))
        else $error("frame start did not restart the counter");

endmodule : tsw_frame
`default_nettype wire

// File: src/tsw_tap.sv
// Test access port controller with a bypass data register.
`timescale 1ns/1ps
`default_nettype none
module tsw_tap import tsw_pkg::*; (
    // Clock and test reset
    input  wire logic clk_i,
    input  wire logic trst_n_i,
    // Test pins
    input  wire logic tck_i,
    input  wire logic tms_i,
    input  wire logic tdi_i,
    output logic      tdo_o,
    output logic      tdo_oe_o
);
    tsw_tap_t   state;
    logic       tck_q;
    logic [3:0] ir;
    logic       byp;

    wire logic tck_rise = tck_i & ~tck_q;
    wire logic tck_fall = ~tck_i & tck_q;
    wire logic shift_ir = state == TAP_SHIR;
    wire logic shift_dr = state == TAP_SHDR;

    function automatic tsw_tap_t tap_next(input tsw_tap_t s, input logic tms);
        case (s)
            TAP_TLR:  tap_next = tms ? TAP_TLR  : TAP_RTI;
            TAP_RTI:  tap_next = tms ? TAP_SDR  : TAP_RTI;
            TAP_SDR:  tap_next = tms ? TAP_SIR  : TAP_CDR;
            TAP_CDR:  tap_next = tms ? TAP_E1DR : TAP_SHDR;
            TAP_SHDR: tap_next = tms ? TAP_E1DR : TAP_SHDR;
            TAP_E1DR: tap_next = tms ? TAP_UDR  : TAP_PDR;
            TAP_PDR:  tap_next = tms ? TAP_E2DR : TAP_PDR;
            TAP_E2DR: tap_next = tms ? TAP_UDR  : TAP_SHDR;
            TAP_SIR:  tap_next = tms ? TAP_TLR  : TAP_CIR;
            TAP_CIR:  tap_next = tms ? TAP_E1IR : TAP_SHIR;
            TAP_SHIR: tap_next = tms ? TAP_E1IR : TAP_SHIR;
            TAP_E1IR: tap_next = tms ? TAP_UIR  : TAP_PIR;
            TAP_PIR:  tap_next = tms ? TAP_E2IR : TAP_PIR;
            TAP_E2IR: tap_next = tms ? TAP_UIR  : TAP_SHIR;
            TAP_UDR,
            TAP_UIR:  tap_next = tms ? TAP_SDR  : TAP_RTI;
            default:  tap_next = TAP_TLR;
        endcase
    endfunction : tap_next

    always_ff @(posedge clk_i or negedge trst_n_i) begin
        if (!trst_n_i) begin
            state    <= TAP_TLR;
            tck_q    <= 1'b0;
            ir       <= TAP_IR_RESET;
            byp      <= 1'b0;
            tdo_o    <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else begin
            tck_q <= tck_i;
            if (tck_rise) begin
                state <= tap_next(state, tms_i);
                if (state == TAP_TLR) begin
                    ir <= TAP_IR_RESET;
                end else if (state == TAP_CIR) begin
                    ir <= TAP_IR_CAPTURE;
                end else if (shift_ir) begin
                    ir <= {tdi_i, ir[3:1]};
                end
                if (state == TAP_CDR) begin
                    byp <= 1'b0;
                end else if (shift_dr) begin
                    byp <= tdi_i;
                end
            end
            if (tck_fall) begin
                tdo_o    <= shift_ir ? ir[0] : byp;
                tdo_oe_o <= shift_ir | shift_dr;
            end
        end
    end

    a_trst_holds_tlr: assert property (@(posedge clk_i)
        !trst_n_i |-> state == TAP_TLR && !tdo_oe_o)
        else $error("test reset did not hold the controller in reset");

    a_tdo_on_fall: assert property (@(posedge clk_i) disable iff (!trst_n_i)
        $changed(tdo_o) || $changed(tdo_oe_o) |-> $past(tck_fall))
        else $error("test data out moved away from a falling test clock");

endmodule : tsw_tap
`default_nettype wire

// File: src/tsw_top.sv
// Time slot interchange switch: serial streams, host port and test port.
//
// Contract
// - Any of 1024 inputs reaches any of 1024 outputs without blocking.
// - Input and output streams carry serial data at 2.048 Mb/s.
// - Each input stream carries 32 eight-bit channels per 125 us frame.
// - Output streams always run at the input data rate.
// - A 4.096 MHz master clock shifts all serial data in and out.
// - Frame pulse format, falling-edge or GCI, is detected automatically.
// - Device reset clears state and floats serial and host data outputs.
// - A host access happens only while strobe and chip select are low.
// - Read/write level sets whether the host data bus is driven or sampled.
// - Without chip select every host access is ignored.
// - A 12-bit address reaches channel map, sample memory and control; 16-bit data.
// - Acknowledge goes low when done, then high briefly, then floats.
// - Enable pin low and standby bit low float all serial outputs.
// - Enable pin high drives outputs; per-channel enable bit can still float.
// - Test reset forces the test controller to its reset state asynchronously.
// - Test data out changes on falling test clock and floats outside scans.
// - Each input stream may lag the frame pulse by up to 4.5 clock cycles.
// - Per channel, output carries switched input data or host-written data.
// - Per channel, choose variable low-latency delay or constant frame delay.
// - A direct host access to any memory completes within one cycle.
// - The frame pulse marks frames and restarts input channel addressing.
// - Falling-edge format samples input on rising edge, three quarters in.
// - GCI format samples input on falling edge, three quarters in.
// - Top four channel map bits: host mode, delay type, enable, loopback.
`timescale 1ns/1ps
`default_nettype none
module tsw_top import tsw_pkg::*; (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    // Serial streams
    input  wire logic              mclk_i,
    input  wire logic              frame_pulse_i,
    input  wire logic [NSTR-1:0]   serial_in_streams_i,
    input  wire logic              serial_output_master_enable_i,
    output logic      [NSTR-1:0]   serial_out_streams_o,
    output logic      [NSTR-1:0]   serial_out_streams_oe_o,
    // Host port
    input  wire logic              cs_n_i,
    input  wire logic              data_strobe_n_i,
    input  wire logic              rw_i,
    input  wire logic [11:0]       host_address_i,
    input  wire logic [15:0]       host_data_bus_i,
    output logic      [15:0]       host_data_bus_o,
    output logic                   host_data_bus_oe_o,
    output logic                   transfer_ack_n_o,
    output logic                   transfer_ack_n_oe_o,
    // Test port
    input  wire logic              tck_i,
    input  wire logic              tms_i,
    input  wire logic              tdi_i,
    input  wire logic              trst_n_i,
    output logic                   tdo_o,
    output logic                   tdo_oe_o
);

    // ==========================================================
    // Submodules
    tsw_tm_if tm ();

    tsw_frame u_frame (
        .clk_i         (clk_i),
        .resetn_i      (resetn_i),
        .mclk_i        (mclk_i),
        .frame_pulse_i (frame_pulse_i),
        .tm            (tm)
    );

    tsw_tap u_tap (
        .clk_i    (clk_i),
        .trst_n_i (trst_n_i),
        .tck_i    (tck_i),
        .tms_i    (tms_i),
        .tdi_i    (tdi_i),
        .tdo_o    (tdo_o),
        .tdo_oe_o (tdo_oe_o)
    );

    // ==========================================================
    // Storage
    logic [15:0]     cm      [NLOC];
    logic [7:0]      dm      [2][NLOC];
    logic [3:0]      ofs     [NSTR];
    logic [7:0]      tx_sr   [NSTR];
    logic [7:0]      in_sr   [NSTR];
    logic [15:0]     cr;
    logic [NSTR-1:0] ch_oe;
    logic            done;
    logic            ack_hi;
    logic [15:0]     rdata;

    function automatic logic [9:0] loc_of(input logic [4:0] st, input logic [4:0] ch);
        loc_of = {st, ch};
    endfunction : loc_of

    // Constant delay always reads last frame's bank; variable delay reads this frame's
    // bank only two slots on, as an offset stream stores its byte up to nine halves late.
    function automatic logic bank_of(input logic [15:0] w, input logic [4:0] och,
                                     input logic par);
        bank_of = (w[CM_CONST_BIT] || {1'b0, w[4:0]} + 6'h01 >= {1'b0, och}) ? ~par : par;
    endfunction : bank_of

    // ==========================================================
    // Host port decode
    wire logic       acc       = ~cs_n_i & ~data_strobe_n_i;
    wire logic       start_acc = acc & ~done;
    wire logic       wr        = start_acc & ~rw_i;
    wire logic [1:0] sel       = host_address_i[11:10];
    wire logic [9:0] loc       = host_address_i[9:0];
    wire logic       is_cr     = (sel == SEL_CTRL) && (loc == CR_ADDR);
    wire logic       is_ofs    = (sel == SEL_CTRL) && (loc[9:5] == OFS_PAGE);
    wire logic [3:0] ofs_wr    = (host_data_bus_i[3:0] > OFS_MAX) ? OFS_MAX
                                                                  : host_data_bus_i[3:0];
    logic [15:0] cr_rd;
    logic [15:0] rd_mux;

    always_comb begin
        cr_rd             = cr;
        cr_rd[CR_GCI_BIT] = tm.gci;
    end

    // Channel map, sample memory (last full frame) and control share one space.
    assign rd_mux = (sel == SEL_CM) ? cm[loc]
                  : (sel == SEL_DM) ? {8'h00, dm[~tm.par][loc]}
                  : is_cr           ? cr_rd
                  : is_ofs          ? {12'h000, ofs[loc[4:0]]}
                  :                   16'h0000;

    // ==========================================================
    // Host handshake
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            done   <= 1'b0;
            ack_hi <= 1'b0;
            rdata  <= 16'h0000;
        end else begin
            done   <= acc;
            ack_hi <= done & ~acc;
            if (start_acc & rw_i) begin
                rdata <= rd_mux;
            end
        end
    end

    assign host_data_bus_o     = rdata;
    assign host_data_bus_oe_o  = done & acc & rw_i;
    assign transfer_ack_n_o    = ack_hi;
    assign transfer_ack_n_oe_o = done | ack_hi;

    // ==========================================================
    // Control and offset registers
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cr <= CR_RESET;
            for (int s = 0; s < NSTR; s++) begin
                ofs[s] <= OFS_RESET;
            end
        end else begin
            if (wr & is_cr) begin
                cr <= host_data_bus_i;
            end
            if (wr & is_ofs) begin
                ofs[loc[4:0]] <= ofs_wr;
            end
        end
    end

    // ==========================================================
    // Channel map memory
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < NLOC; i++) begin
                cm[i] <= 16'h0000;
            end
        end else if (wr && sel == SEL_CM) begin
            cm[loc] <= host_data_bus_i;
        end
    end

    // ==========================================================
    // Per-stream selection
    wire logic [4:0] out_ch   = tm.hc[9:5];
    wire logic       bit_edge = tm.tick && tm.hc[1:0] == 2'h0;
    wire logic       ch_load  = bit_edge && tm.hc[4:2] == 3'h0;
    wire logic       master   = serial_output_master_enable_i | cr[CR_OSB_BIT];

    logic [15:0]     cw        [NSTR];
    logic [7:0]      next_byte [NSTR];
    logic [HC_W-1:0] hs        [NSTR];
    logic [NSTR-1:0] lpbk;
    logic [NSTR-1:0] in_bit;

    always_comb begin
        for (int s = 0; s < NSTR; s++) begin
            cw[s]        = cm[loc_of(5'(s), out_ch)];
            next_byte[s] = cw[s][CM_HOST_BIT] ? cw[s][7:0]
                         : dm[bank_of(cw[s], out_ch, tm.par)][cw[s][9:0]];
            hs[s]        = tm.hc - {6'h00, ofs[s]};
            lpbk[s]      = cm[loc_of(5'(s), hs[s][9:5])][CM_LPBK_BIT];
            in_bit[s]    = lpbk[s] ? serial_out_streams_o[s] : serial_in_streams_i[s];
        end
    end

    // ==========================================================
    // Output shifters
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ch_oe <= {NSTR{1'b0}};
            for (int s = 0; s < NSTR; s++) begin
                tx_sr[s] <= 8'h00;
            end
        end else if (bit_edge) begin
            for (int s = 0; s < NSTR; s++) begin
                if (ch_load) begin
                    tx_sr[s] <= next_byte[s];
                    ch_oe[s] <= cw[s][CM_OE_BIT];
                end else begin
                    tx_sr[s] <= {tx_sr[s][6:0], 1'b0};
                end
            end
        end
    end

    always_comb begin
        for (int s = 0; s < NSTR; s++) begin
            serial_out_streams_o[s] = tx_sr[s][7];
        end
    end

    assign serial_out_streams_oe_o = {NSTR{master}} & ch_oe;

    // ==========================================================
    // Input sampling into the sample memory
    // The half-cycle counter restarts on the boundary edge of whichever
    // format is present, so count three is always the three-quarter edge.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            for (int s = 0; s < NSTR; s++) begin
                in_sr[s] <= 8'h00;
            end
            for (int i = 0; i < NLOC; i++) begin
                dm[0][i] <= 8'h00;
                dm[1][i] <= 8'h00;
            end
        end else if (tm.tick) begin
            for (int s = 0; s < NSTR; s++) begin
                if (hs[s][1:0] == 2'h3) begin
                    in_sr[s] <= {in_sr[s][6:0], in_bit[s]};
                    if (hs[s][4:2] == 3'h7) begin
                        dm[tm.par][loc_of(5'(s), hs[s][9:5])] <= {in_sr[s][6:0], in_bit[s]};
                    end
                end
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_ack_low;
        !transfer_ack_n_o && transfer_ack_n_oe_o;
    endsequence

    sequence s_ack_high_release;
        transfer_ack_n_o && transfer_ack_n_oe_o ##1 !transfer_ack_n_oe_o;
    endsequence

    a_ack_goes_low: assert property ((start_acc ##1 acc) |-> s_ack_low)
        else $error("acknowledge not low one cycle after access start");

    a_ack_release: assert property ((done && !acc ##1 !acc) |-> s_ack_high_release)
        else $error("acknowledge not driven high then released");

    a_read_data: assert property ((start_acc && rw_i ##1 acc && rw_i)
        |-> host_data_bus_oe_o && host_data_bus_o == $past(rd_mux))
        else $error("read data not presented on the host bus");

    a_cm_write: assert property (wr && sel == SEL_CM
        |=> cm[$past(loc)] == $past(host_data_bus_i))
        else $error("channel map write lost");

    a_no_cs_idle: assert property (cs_n_i [*2]
        |=> !transfer_ack_n_oe_o && !host_data_bus_oe_o)
        else $error("host port answered without chip select");

    a_master_off: assert property (!serial_output_master_enable_i && !cr[CR_OSB_BIT]
        |-> serial_out_streams_oe_o == {NSTR{1'b0}})
        else $error("serial outputs driven while master enables are off");

    a_chan_oe_off: assert property (ch_load && !cw[0][CM_OE_BIT]
        |=> !serial_out_streams_oe_o[0])
        else $error("disabled channel still driven");

    a_host_mode_out: assert property (ch_load && cw[0][CM_HOST_BIT]
        |=> serial_out_streams_o[0] == $past(cw[0][7]))
        else $error("host mode channel did not send host data");

    a_reset_hiz: assert property (@(posedge clk_i) disable iff (1'b0) !resetn_i
        |=> serial_out_streams_oe_o == {NSTR{1'b0}} && !host_data_bus_oe_o
            && !transfer_ack_n_oe_o)
        else $error("outputs driven during device reset");

endmodule : tsw_top
`default_nettype wire
